// *** logic/prc_pkg.sv ***
// Constants, types and check-code functions shared by the system RAM controller files.
// Assumes a single 50 MHz clk_sys; users name every item as prc_pkg::name.
package prc_pkg;

  // ****************************************
  // Sizes and encodings
  // ****************************************
  localparam int         IDX_W    = 10;
  localparam int         WORDS    = 2 ** IDX_W;
  localparam int         DW       = 64;
  localparam int         CW       = 8;
  localparam int         MW       = DW + CW;
  localparam int         PROT_W   = DW + IDX_W;
  localparam int         POS_W    = 7;
  localparam int         IDX_LSB  = 3;
  localparam int         CLK_MHZ  = 50;
  localparam logic [1:0] TR_SEQ   = 2'h3;
  localparam logic [2:0] SZ_DWORD = 3'h3;
  localparam logic       RDY_RST  = 1'h1;

  typedef enum logic [1:0] {
    P_IDLE  = 2'h0,
    P_ISSUE = 2'h1,
    P_RD    = 2'h3,
    P_WAIT  = 2'h2
  } prc_pst_t;

  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_COMMIT = 3'h1,
    OP_BACK   = 3'h2,
    OP_FRONT  = 3'h3,
    OP_PF     = 3'h4
  } prc_op_t;

  typedef struct packed {
    logic [DW-1:0] data;
    logic          ce;
    logic          ue;
  } prc_dec_t;

  // ****************************************
  // Check code over data and doubleword index
  // ****************************************
  // Protected bit i sits at the i-th Hamming position that is not a power of two
  function automatic logic [POS_W-1:0] posOf(input int i);
    int               n;
    logic [POS_W-1:0] r;
    n = 0;
    r = '0;
    for (int p = 3; p < 128; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (n == i) r = p[POS_W-1:0];
        n++;
      end
    end
    return r;
  endfunction : posOf

  function automatic logic [CW-1:0] encode(input logic [DW-1:0] d, input logic [IDX_W-1:0] x);
    logic [PROT_W-1:0] v;
    logic [POS_W-1:0]  p;
    logic [CW-1:0]     c;
    v = {x, d};
    c = '0;
    for (int i = 0; i < PROT_W; i++) begin
      p = posOf(i);
      for (int j = 0; j < POS_W; j++) begin
        if (p[j]) c[j] = c[j] ^ v[i];
      end
    end
    c[CW-1] = ^{v, c[POS_W-1:0]};
    return c;
  endfunction : encode

  function automatic prc_dec_t decode(input logic [DW-1:0] d, input logic [IDX_W-1:0] x,
                                      input logic [CW-1:0] k);
    logic [CW-1:0] syn;
    logic          odd;
    logic          hit;
    logic          chkBit;
    prc_dec_t      r;
    syn    = encode(d, x) ^ k;
    odd    = ^{x, d, k};
    hit    = 1'b0;
    r.data = d;
    r.ce   = 1'b0;
    r.ue   = 1'b0;
    for (int i = 0; i < PROT_W; i++) begin
      if (odd && posOf(i) == syn[POS_W-1:0]) begin
        hit = 1'b1;
        if (i < DW) r.data[i[5:0]] = ~d[i[5:0]];
        else r.ue = 1'b1;
      end
    end
    chkBit = $onehot0(syn[POS_W-1:0]);
    if (odd) begin
      r.ce = !r.ue && (hit || chkBit);
      r.ue = r.ue || !(hit || chkBit);
    end else begin
      r.ue = syn[POS_W-1:0] != '0;
    end
    return r;
  endfunction : decode

endpackage : prc_pkg

// *** logic/prc_mem_if.sv ***
// Array port between the controller and its RAM module.
// Assumes both ends run on clk_sys; read data lag the request by one edge.
interface prc_mem_if;
  logic                        en;
  logic                        we;
  logic [prc_pkg::IDX_W-1:0]   idx;
  logic [prc_pkg::MW-1:0]      wdata;
  logic [prc_pkg::MW-1:0]      rdata;

  modport ctrl (output en, output we, output idx, output wdata, input rdata);
  modport ram  (input en, input we, input idx, input wdata, output rdata);
endinterface : prc_mem_if

// *** logic/prc_ram.sv ***
// Single-port array of doublewords with their check bytes.
// Assumes one request per edge; contents are undefined until written.
module prc_ram (
  input logic    clk_sys,
  prc_mem_if.ram mem
);
  typedef struct packed {
    logic [prc_pkg::MW-1:0] rdata;
  } prc_ram_state_t;

  logic [prc_pkg::MW-1:0] cells [prc_pkg::WORDS];
  prc_ram_state_t         st;
  prc_ram_state_t         next_st;

  // Only reads load the read register, so a pending prefetch survives idle cycles
  always_comb begin
    next_st = st;
    if (mem.en && !mem.we) next_st.rdata = cells[mem.idx];
  end

  always_ff @(posedge clk_sys) begin
    st <= next_st;
    if (mem.en && mem.we) cells[mem.idx] <= mem.wdata;
  end

  assign mem.rdata = st.rdata;
endmodule : prc_ram

// *** logic/prc_ram_ctrl.sv ***
// System RAM controller: front-door and back-door AHB-Lite slaves over one checked array.
// Assumes both masters synchronous to clk_sys and the array inside prc_ram.
// What this block does
// - Reads take zero or one programmed wait state, chosen by waitStateSel.
// - Byte, halfword, word and doubleword reads and writes are served.
// - Full doubleword writes finish with no added wait state.
// - Narrower writes stall one cycle for read, check, merge and re-encode.
// - Follow-on beats of an incrementing doubleword read burst come with zero wait states.
// - Array words are 64 data bits plus 8 check bits.
// - A store buffer retires writes at once and commits them later.
// - A second AHB port serves the flash controller's overlay reads.
// - Back-door requests win arbitration over front-door and prefetch reads; store-buffer commits go first.
// - Back-door requests preempt front-door transfers, bursts included.
// - The check code covers the doubleword address as well as data.
// - Single-bit errors are corrected, double-bit errors detected.
// - Uncorrectable error on a narrow write's read adds one wait state.
// - Single-bit data errors raise a correctable event.
// - Multi-bit, address or unused-bit errors raise an uncorrectable event.
module prc_ram_ctrl (
  input  logic                      clk_sys,
  input  logic                      rst,
  input  logic                      waitStateSel,
  input  logic                      fHsel,
  input  logic [31:0]               fHaddr,
  input  logic [1:0]                fHtrans,
  input  logic                      fHwrite,
  input  logic [2:0]                fHsize,
  input  logic [63:0]               fHwdata,
  input  logic                      fHready,
  output logic                      fHreadyout,
  output logic [63:0]               fHrdata,
  output logic                      fHresp,
  input  logic                      bHsel,
  input  logic [31:0]               bHaddr,
  input  logic [1:0]                bHtrans,
  input  logic                      bHwrite,
  input  logic                      bHready,
  output logic                      bHreadyout,
  output logic [63:0]               bHrdata,
  output logic                      bHresp,
  output logic                      eccCorrEvt,
  output logic                      eccUncorrEvt,
  output logic [prc_pkg::IDX_W-1:0] eccErrIdx
);
  typedef struct packed {
    prc_pkg::prc_pst_t         fSt;
    prc_pkg::prc_pst_t         bSt;
    logic                      fRdy;
    logic                      bRdy;
    logic                      fErr;
    logic                      bErr;
    logic                      fWr;
    logic                      wdPend;
    logic                      sbValid;
    logic                      pfWant;
    logic                      pfLive;
    logic                      ce;
    logic                      ue;
    logic [2:0]                fOff;
    logic [2:0]                fSize;
    logic [prc_pkg::IDX_W-1:0] fIdx;
    logic [prc_pkg::IDX_W-1:0] bIdx;
    logic [prc_pkg::IDX_W-1:0] wdIdx;
    logic [prc_pkg::IDX_W-1:0] sbIdx;
    logic [prc_pkg::IDX_W-1:0] pfIdx;
    logic [prc_pkg::IDX_W-1:0] errIdx;
    logic [63:0]               fRdata;
    logic [63:0]               bRdata;
    logic [63:0]               fHold;
    logic [63:0]               bHold;
    logic [63:0]               sbData;
  } prc_state_t;

  prc_state_t                st;
  prc_state_t                next_st;
  prc_pkg::prc_dec_t         dec;
  prc_pkg::prc_op_t          op;
  logic                      fAcc;
  logic                      bAcc;
  logic                      fDw;
  logic                      pfHit;
  logic                      fNeed;
  logic                      bNeed;
  logic                      hold;
  logic                      decUse;
  logic [63:0]               merged;
  logic [prc_pkg::IDX_W-1:0] fAddrIdx;
  logic [prc_pkg::IDX_W-1:0] bAddrIdx;
  logic [prc_pkg::IDX_W-1:0] pfIdxNow;
  logic [prc_pkg::IDX_W-1:0] decIdx;
  prc_mem_if                 mem ();

  prc_ram u_ram (
    .clk_sys (clk_sys),
    .mem     (mem)
  );

  // ****************************************
  // Request decode and array arbitration
  // ****************************************
  assign fAddrIdx = fHaddr[prc_pkg::IDX_LSB +: prc_pkg::IDX_W];
  assign bAddrIdx = bHaddr[prc_pkg::IDX_LSB +: prc_pkg::IDX_W];
  assign fAcc     = fHsel && fHtrans[1] && fHready && st.fRdy;
  assign bAcc     = bHsel && bHtrans[1] && bHready && st.bRdy;
  assign fDw      = fHsize == prc_pkg::SZ_DWORD;
  assign pfHit    = fAcc && !fHwrite && fHtrans == prc_pkg::TR_SEQ && st.pfLive && fAddrIdx == st.pfIdx;
  // Data of a just-taken doubleword write lands next edge; reads wait so none sees stale cells
  assign hold     = st.sbValid || st.wdPend;
  assign bNeed    = (bAcc && !bHwrite) || st.bSt == prc_pkg::P_ISSUE;
  assign fNeed    = (fAcc && !pfHit && !(fHwrite && fDw) && fHsize <= prc_pkg::SZ_DWORD)
                 || st.fSt == prc_pkg::P_ISSUE;
  assign pfIdxNow = pfHit ? st.pfIdx + 1'b1 : (st.fSt == prc_pkg::P_RD ? st.fIdx + 1'b1 : st.pfIdx);
  // Buffer commit is internal housekeeping and always goes first, then back door, front door, prefetch
  assign op = st.sbValid ? prc_pkg::OP_COMMIT
            : (hold ? prc_pkg::OP_NONE
            : (bNeed ? prc_pkg::OP_BACK
            : (fNeed ? prc_pkg::OP_FRONT
            : ((st.pfWant || pfHit || (st.fSt == prc_pkg::P_RD && !st.fWr)) ? prc_pkg::OP_PF
            : prc_pkg::OP_NONE))));

  assign mem.en    = op != prc_pkg::OP_NONE;
  assign mem.we    = op == prc_pkg::OP_COMMIT;
  assign mem.idx   = op == prc_pkg::OP_COMMIT ? st.sbIdx
                   : op == prc_pkg::OP_BACK ? (bAcc ? bAddrIdx : st.bIdx)
                   : op == prc_pkg::OP_FRONT ? (fAcc ? fAddrIdx : st.fIdx) : pfIdxNow;
  assign mem.wdata = {prc_pkg::encode(st.sbData, st.sbIdx), st.sbData};

  // ****************************************
  // Check, correct and merge
  // ****************************************
  assign decIdx = st.bSt == prc_pkg::P_RD ? st.bIdx : (pfHit ? st.pfIdx : st.fIdx);
  assign dec    = prc_pkg::decode(mem.rdata[63:0], decIdx, mem.rdata[71:64]);
  assign decUse = st.fSt == prc_pkg::P_RD || st.bSt == prc_pkg::P_RD || pfHit;

  for (genvar g = 0; g < 8; g++) begin : gMerge
    logic sel;
    assign sel = 3'(g) >= st.fOff && 4'(g) < 4'(st.fOff) + (4'h1 << st.fSize);
    assign merged[8*g +: 8] = sel ? fHwdata[8*g +: 8] : dec.data[8*g +: 8];
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st    = st;
    next_st.ce = decUse && dec.ce;
    next_st.ue = decUse && dec.ue;
    if (decUse && (dec.ce || dec.ue)) next_st.errIdx = decIdx;
    if (op != prc_pkg::OP_NONE) next_st.pfLive = op == prc_pkg::OP_PF;
    if (op == prc_pkg::OP_PF || pfHit || (st.fSt == prc_pkg::P_RD && !st.fWr)) begin
      next_st.pfIdx  = pfIdxNow;
      next_st.pfWant = op != prc_pkg::OP_PF;
    end
    if (op == prc_pkg::OP_COMMIT) next_st.sbValid = 1'b0;
    if (st.wdPend) begin
      next_st.wdPend  = 1'b0;
      next_st.sbValid = 1'b1;
      next_st.sbIdx   = st.wdIdx;
      next_st.sbData  = fHwdata;
    end
    unique case (st.fSt)
      prc_pkg::P_IDLE: begin
        next_st.fErr = 1'b0;
        if (fAcc && fHsize > prc_pkg::SZ_DWORD) begin
          next_st.fRdy = 1'b0;
          next_st.fErr = 1'b1;
          next_st.fSt  = prc_pkg::P_WAIT;
        end else if (fAcc && fHwrite && fDw) begin
          next_st.wdPend = 1'b1;
          next_st.wdIdx  = fAddrIdx;
        end else if (pfHit) begin
          next_st.fRdata = dec.data;
        end else if (fAcc) begin
          next_st.fRdy  = 1'b0;
          next_st.fIdx  = fAddrIdx;
          next_st.fOff  = fHaddr[2:0];
          next_st.fSize = fHsize;
          next_st.fWr   = fHwrite;
          next_st.fSt   = op == prc_pkg::OP_FRONT ? prc_pkg::P_RD : prc_pkg::P_ISSUE;
        end
      end
      prc_pkg::P_ISSUE: begin
        if (op == prc_pkg::OP_FRONT) next_st.fSt = prc_pkg::P_RD;
      end
      prc_pkg::P_RD: begin
        next_st.fHold = dec.data;
        if (st.fWr) begin
          next_st.sbValid = 1'b1;
          next_st.sbIdx   = st.fIdx;
          next_st.sbData  = merged;
          next_st.fRdy    = !dec.ue;
          next_st.fSt     = dec.ue ? prc_pkg::P_WAIT : prc_pkg::P_IDLE;
        end else if (waitStateSel) begin
          next_st.fSt = prc_pkg::P_WAIT;
        end else begin
          next_st.fRdata = dec.data;
          next_st.fRdy   = 1'b1;
          next_st.fSt    = prc_pkg::P_IDLE;
        end
      end
      prc_pkg::P_WAIT: begin
        next_st.fRdata = st.fHold;
        next_st.fRdy   = 1'b1;
        next_st.fSt    = prc_pkg::P_IDLE;
      end
    endcase
    unique case (st.bSt)
      prc_pkg::P_IDLE: begin
        next_st.bErr = 1'b0;
        if (bAcc) begin
          // Overlay port is read-only; writes get the two-cycle error answer
          next_st.bRdy = 1'b0;
          next_st.bErr = bHwrite;
          next_st.bIdx = bAddrIdx;
          next_st.bSt  = bHwrite ? prc_pkg::P_WAIT
                       : (op == prc_pkg::OP_BACK ? prc_pkg::P_RD : prc_pkg::P_ISSUE);
        end
      end
      prc_pkg::P_ISSUE: begin
        if (op == prc_pkg::OP_BACK) next_st.bSt = prc_pkg::P_RD;
      end
      prc_pkg::P_RD: begin
        next_st.bHold = dec.data;
        if (waitStateSel) begin
          next_st.bSt = prc_pkg::P_WAIT;
        end else begin
          next_st.bRdata = dec.data;
          next_st.bRdy   = 1'b1;
          next_st.bSt    = prc_pkg::P_IDLE;
        end
      end
      prc_pkg::P_WAIT: begin
        next_st.bRdata = st.bHold;
        next_st.bRdy   = 1'b1;
        next_st.bSt    = prc_pkg::P_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st      <= '0;
      st.fRdy <= prc_pkg::RDY_RST;
      st.bRdy <= prc_pkg::RDY_RST;
    end else begin
      st <= next_st;
    end
  end

  assign fHreadyout   = st.fRdy;
  assign fHrdata      = st.fRdata;
  assign fHresp       = st.fErr;
  assign bHreadyout   = st.bRdy;
  assign bHrdata      = st.bRdata;
  assign bHresp       = st.bErr;
  assign eccCorrEvt   = st.ce;
  assign eccUncorrEvt = st.ue;
  assign eccErrIdx    = st.errIdx;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence stallOne;
    !fHreadyout ##1 fHreadyout;
  endsequence
  sequence bufFilled;
    st.sbValid && st.sbData == $past(fHwdata);
  endsequence

  read_zero_wait_a: assert property (st.fSt == prc_pkg::P_RD && !st.fWr && !waitStateSel
    |=> fHreadyout && fHrdata == $past(dec.data)) else $error("Read without wait state late");
  read_one_wait_a: assert property (st.fSt == prc_pkg::P_RD && !st.fWr && waitStateSel
    |=> !fHreadyout ##1 (fHreadyout && fHrdata == $past(dec.data, 2))) else $error("Wait-state read wrong");
  dword_write_a: assert property (fAcc && fHwrite && fDw
    |=> fHreadyout ##1 bufFilled) else $error("Doubleword write stalled or lost");
  narrow_write_a: assert property (fAcc && fHwrite && !fDw && op == prc_pkg::OP_FRONT
    |=> !fHreadyout ##1 (fHreadyout || st.fSt == prc_pkg::P_WAIT)) else $error("Narrow write stall wrong");
  burst_hit_a: assert property (pfHit
    |=> fHreadyout && fHrdata == $past(dec.data)) else $error("Burst beat not zero wait");
  buf_commit_a: assert property (st.sbValid |-> mem.we && mem.idx == st.sbIdx)
    else $error("Store buffer not committed");
  back_first_a: assert property (bNeed && !hold |-> op == prc_pkg::OP_BACK)
    else $error("Back door lost arbitration");
  back_preempt_a: assert property (fNeed && bNeed && !hold
    |=> st.fSt == prc_pkg::P_ISSUE) else $error("Front door not held off");
  ue_extra_wait_a: assert property (st.fSt == prc_pkg::P_RD && st.fWr && dec.ue
    |=> stallOne) else $error("Missing extra wait state");
  ce_event_a: assert property (decUse && dec.ce |=> eccCorrEvt && !eccUncorrEvt)
    else $error("Correctable event missing");
  ue_event_a: assert property (decUse && dec.ue |=> eccUncorrEvt && eccErrIdx == $past(decIdx))
    else $error("Uncorrectable event missing");
  rmw_merge_a: assert property (st.fSt == prc_pkg::P_RD && st.fWr && !dec.ue
    |=> st.sbValid && st.sbIdx == $past(st.fIdx)) else $error("Merged word not buffered");
endmodule : prc_ram_ctrl

// *** verification/prc_flash_master.sv ***
// Back-door master model standing in for the flash controller overlay path.
// Assumes the bench calls access one at a time and one slave sits on this port.
module prc_flash_master (
  input  logic        clk_sys,
  input  logic        bHreadyout,
  input  logic [63:0] bHrdata,
  input  logic        bHresp,
  output logic        bHsel,
  output logic [31:0] bHaddr,
  output logic [1:0]  bHtrans,
  output logic        bHwrite,
  output logic        bHready
);
  timeunit 1ns;
  timeprecision 1ps;

  assign bHready = bHreadyout;

  initial begin
    bHsel   = 1'b0;
    bHaddr  = 32'h0;
    bHtrans = 2'h0;
    bHwrite = 1'b0;
  end

  // Released address is inverted so a stale value never looks valid
  task automatic access(input logic wr, input logic [31:0] a, output logic [63:0] d, output int w,
                        output logic e);
    int n;
    @(posedge clk_sys);
    bHsel   <= 1'b1;
    bHaddr  <= a;
    bHtrans <= 2'h2;
    bHwrite <= wr;
    @(posedge clk_sys);
    bHsel   <= 1'b0;
    bHtrans <= 2'h0;
    bHaddr  <= ~a;
    n = 0;
    e = 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
      e = e | bHresp;
    end while (bHreadyout !== 1'b1 && n < 50);
    d = bHrdata;
    w = n - 1;
  endtask : access
endmodule : prc_flash_master

// *** verification/prc_ram_ctrl_bench.sv ***
// Self-checking bench for the system RAM controller: single transfers, bursts, back door.
// Assumes prc_ram_ctrl holds its own array and prc_flash_master drives the back door.
module prc_ram_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Design and partner
  // ****************************************
  logic                      clk_sys      = 1'b0;
  logic                      rst          = 1'b1;
  logic                      waitStateSel = 1'b0;
  logic                      fHsel        = 1'b0;
  logic [31:0]               fHaddr       = 32'h0;
  logic [1:0]                fHtrans      = 2'h0;
  logic                      fHwrite      = 1'b0;
  logic [2:0]                fHsize       = 3'h0;
  logic [63:0]               fHwdata      = 64'h0;
  logic                      fHready;
  logic                      fHreadyout;
  logic [63:0]               fHrdata;
  logic                      fHresp;
  logic                      bHsel;
  logic [31:0]               bHaddr;
  logic [1:0]                bHtrans;
  logic                      bHwrite;
  logic                      bHready;
  logic                      bHreadyout;
  logic [63:0]               bHrdata;
  logic                      bHresp;
  logic                      eccCorrEvt;
  logic                      eccUncorrEvt;
  logic [prc_pkg::IDX_W-1:0] eccErrIdx;
  logic [63:0]               img [16];
  logic [63:0]               rd [4];
  int                        waits [4];
  logic                      resp;
  int                        badCount   = 0;
  int                        checksDone = 0;
  int                        evtCount   = 0;

  always #10ns clk_sys = ~clk_sys;
  // Only slave on the front bus
  assign fHready = fHreadyout;

  prc_ram_ctrl dut (.clk_sys, .rst, .waitStateSel, .fHsel, .fHaddr, .fHtrans, .fHwrite, .fHsize, .fHwdata,
    .fHready, .fHreadyout, .fHrdata, .fHresp, .bHsel, .bHaddr, .bHtrans, .bHwrite, .bHready, .bHreadyout,
    .bHrdata, .bHresp, .eccCorrEvt, .eccUncorrEvt, .eccErrIdx);

  prc_flash_master fm (.clk_sys, .bHreadyout, .bHrdata, .bHresp, .bHsel, .bHaddr, .bHtrans, .bHwrite,
    .bHready);

  always @(posedge clk_sys) begin
    if (!rst && (eccCorrEvt !== 1'b0 || eccUncorrEvt !== 1'b0)) evtCount++;
  end

  // ****************************************
  // Checking and transfers
  // ****************************************
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [63:0] laneMask(input logic [2:0] sz, input logic [2:0] off);
    logic [63:0] m;
    m = (sz == prc_pkg::SZ_DWORD) ? '1 : ((64'h1 << (8 << sz)) - 64'h1);
    return m << (8 * off);
  endfunction : laneMask

  // Pipelined incrementing transfer; beat i address goes out in beat i-1 data phase
  task automatic front(input logic wr, input logic [2:0] sz, input logic [31:0] a, input int beats,
                       input logic [63:0] wd);
    int n;
    @(posedge clk_sys);
    fHsel   <= 1'b1;
    fHtrans <= 2'h2;
    fHaddr  <= a;
    fHwrite <= wr;
    fHsize  <= sz;
    @(posedge clk_sys);
    resp = 1'b0;
    for (int i = 0; i < beats; i++) begin
      if (i + 1 < beats) begin
        fHtrans <= prc_pkg::TR_SEQ;
        fHaddr  <= a + 32'((i + 1) * 8);
      end else begin
        fHtrans <= 2'h0;
        fHsel   <= 1'b0;
        fHaddr  <= ~a;
      end
      fHwdata <= wd;
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
        resp = resp | fHresp;
      end while (fHreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
        badCount++;
        tallyAndFinish();
      end
      waits[i] = n - 1;
      rd[i] = fHrdata;
    end
  endtask : front

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic fillTest();
    for (int i = 0; i < 16; i++) begin
      img[i] = {32'h5a000000 | 32'(i), ~(32'(i) * 32'h01010101)};
      front(1'b1, prc_pkg::SZ_DWORD, 32'(i * 8), 1, img[i]);
      check("dword write waits", 64'(waits[0]), 64'h0);
    end
    front(1'b0, prc_pkg::SZ_DWORD, 32'h78, 1, 64'h0);
    check("read behind buffered write", rd[0], img[15]);
    for (int s = 0; s < 2; s++) begin
      waitStateSel <= s[0];
      repeat (3) @(posedge clk_sys);
      for (int i = 0; i < 16; i += 5) begin
        front(1'b0, prc_pkg::SZ_DWORD, 32'(i * 8), 1, 64'h0);
        check("read waits", 64'(waits[0]), 64'(1 + s));
        check("read data", rd[0], img[i]);
        check("read response okay", {63'h0, resp}, 64'h0);
      end
    end
  endtask : fillTest

  task automatic narrowTest();
    logic [2:0]  off;
    logic [63:0] m;
    logic [63:0] wd;
    for (int k = 0; k < 3; k++) begin
      off = 3'(k == 2 ? 4 : 5 + k);
      m = laneMask(3'(k), off);
      wd = 64'hfedcba9876543210 ^ 64'(k * 17);
      img[4] = (img[4] & ~m) | (wd & m);
      repeat (3) @(posedge clk_sys);
      front(1'b1, 3'(k), 32'h20 + 32'(off), 1, wd);
      check("narrow write waits", 64'(waits[0]), 64'h1);
      repeat (3) @(posedge clk_sys);
      front(1'b0, 3'(k), 32'h20 + 32'(off), 1, 64'h0);
      check("narrow read lanes", rd[0] & m, img[4] & m);
      front(1'b0, prc_pkg::SZ_DWORD, 32'h20, 1, 64'h0);
      check("merged dword", rd[0], img[4]);
    end
  endtask : narrowTest

  task automatic burstTest();
    for (int s = 0; s < 2; s++) begin
      waitStateSel <= s[0];
      repeat (3) @(posedge clk_sys);
      front(1'b0, prc_pkg::SZ_DWORD, 32'h40, 4, 64'h0);
      for (int b = 0; b < 4; b++) begin
        check("burst waits", 64'(waits[b]), 64'(b == 0 ? 1 + s : 0));
        check("burst data", rd[b], img[8 + b]);
      end
    end
  endtask : burstTest

  // Back door starts with the burst, then two cycles into it
  task automatic backTest();
    logic [63:0] bd;
    int          bw;
    logic        be;
    waitStateSel <= 1'b0;
    for (int d = 0; d < 3; d += 2) begin
      repeat (3) @(posedge clk_sys);
      fork
        front(1'b0, prc_pkg::SZ_DWORD, 32'h0, 4, 64'h0);
        begin
          repeat (d) @(posedge clk_sys);
          fm.access(1'b0, 32'h68, bd, bw, be);
        end
      join
      check("back door waits", 64'(bw), 64'h1);
      check("back door data", bd, img[13]);
      for (int b = 0; b < 4; b++) check("preempted burst data", rd[b], img[b]);
    end
    repeat (3) @(posedge clk_sys);
    fm.access(1'b1, 32'h0, bd, bw, be);
    check("back door write refused", {63'h0, be}, 64'h1);
    check("back door write waits", 64'(bw), 64'h1);
    waitStateSel <= 1'b1;
    repeat (3) @(posedge clk_sys);
    fm.access(1'b0, 32'h68, bd, bw, be);
    check("back door one wait state", 64'(bw), 64'h2);
    check("back door slow data", bd, img[13]);
  endtask : backTest

  // Check code alone, since the array cannot be corrupted from outside
  task automatic codeTest();
    prc_pkg::prc_dec_t      r;
    logic [63:0]            d;
    logic [prc_pkg::CW-1:0] k;
    d = img[5];
    k = prc_pkg::encode(d, 10'h5);
    for (int b = 0; b < 63; b += 9) begin
      r = prc_pkg::decode(d ^ (64'h1 << b), 10'h5, k);
      check("single flip data", r.data, d);
      check("single flip events", {62'h0, r.ce, r.ue}, 64'h2);
      r = prc_pkg::decode(d ^ (64'h3 << b), 10'h5, k);
      check("double flip events", {62'h0, r.ce, r.ue}, 64'h1);
    end
    r = prc_pkg::decode(d, 10'h7, k);
    check("index fault events", {62'h0, r.ce, r.ue}, 64'h1);
    check("error index idle", 64'(eccErrIdx), 64'h0);
  endtask : codeTest

  // ****************************************
  // Run control
  // ****************************************
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tallyAndFinish

  initial begin
    repeat (20000) @(posedge clk_sys);
    badCount++;
    tallyAndFinish();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check("ready after reset", {62'h0, fHreadyout, bHreadyout}, 64'h3);
    fillTest();
    narrowTest();
    burstTest();
    backTest();
    codeTest();
    repeat (3) @(posedge clk_sys);
    front(1'b1, 3'h4, 32'h8, 1, 64'h0);
    check("oversize error", {63'h0, resp}, 64'h1);
    check("events on clean data", 64'(evtCount), 64'h0);
    tallyAndFinish();
  end
endmodule : prc_ram_ctrl_bench
